// File: rtl/msh_regs.svh
// register map, field positions, reset values and timing figures of the
// motion sensor host register block; definitions only
`ifndef MSH_REGS_SVH
`define MSH_REGS_SVH

// register addresses on the serial register link
`define MSH_ADDR_FIFO_PREV 7'h17
`define MSH_ADDR_FIFO_POP 7'h18
`define MSH_ADDR_FIFO_NEXT 7'h19
`define MSH_ADDR_RESTART 7'h1F
`define MSH_ADDR_LVL_UPPER 7'h20
`define MSH_ADDR_LVL_LOWER 7'h21
`define MSH_ADDR_PERSIST 7'h22

// command byte layout: read flag on top, address below
`define MSH_CMD_READ_BIT 7

// restart key and the value that a read of the restart register shows
`define MSH_RESTART_KEY 8'h52
`define MSH_RESTART_READ 8'h00

// reset values of the stored fields
`define MSH_RST_LVL_UPPER 7'h00
`define MSH_RST_LVL_LOWER 6'h00
`define MSH_RST_PERSIST 8'h00

// field positions of the split motion level
`define MSH_UPPER_MSB 6
`define MSH_LOWER_LSB 2

// restart latency and the clock rate it is counted at
`define MSH_RST_LAT_MS 7.5
`define MSH_CLK_MHZ 250.0

`endif

// File: rtl/msh_pkg.sv
// types shared by the motion sensor host register block
// assumes nothing beyond a systemverilog compiler
package msh_pkg;
    typedef logic [7:0] msh_byte_t;           // one register byte
    typedef logic signed [13:0] msh_sample_t; // signed axis sample
    typedef logic [12:0] msh_level_t;         // unsigned motion level
    typedef enum logic [1:0] {LINK_IDLE, LINK_CMD, LINK_WRITE, LINK_READ} msh_link_e;
endpackage

// File: rtl/msh_act_if.sv
// carrier between the register block and its activity detector
// assumes both ends run on the same system clock
`timescale 1ns/100ps
interface msh_act_if;
    import msh_pkg::*;
    msh_level_t level;      // motion level in raw codes
    logic [7:0] persist;    // consecutive samples needed
    logic clear;            // restart clears the run
    logic smp_valid;        // one new sample set
    msh_sample_t smp [3];   // x, y, z samples
    logic act_evt;          // activity event pulse
    modport ctrl (output level, persist, clear, smp_valid, smp, input act_evt);
    modport det (input level, persist, clear, smp_valid, smp, output act_evt);
endinterface

// File: rtl/msh_act_det.sv
// activity detector: magnitude of each axis against the motion level
// assumes samples arrive on the system clock, one strobe per sample set
`timescale 1ns/100ps
module msh_act_det
    import msh_pkg::*;
(
    input wire logic sys_clk_i, // system clock
    input wire logic reset_n_i, // async reset, active low
    msh_act_if.det act          // level, samples and event
);
    logic [2:0] over;        // axis above level
    logic hit;               // any axis above level
    logic [7:0] target;      // effective run length
    logic [7:0] cnt_q;       // current run length
    logic [7:0] cnt_d;
    logic evt_q;             // event flop
    logic evt_d;

    // per axis magnitude, compared in raw codes so range scaling is implicit
    for (genvar i = 0; i < 3; i++)
    begin : g_axis
        logic [13:0] mag;
        // negating the most negative code still fits as unsigned 14 bits
        assign mag = act.smp[i][13] ? 14'(-act.smp[i]) : 14'(act.smp[i]);
        assign over[i] = mag > {1'b0, act.level};
    end

    assign hit = act.smp_valid && (|over);
    // a zero count still needs one sample, otherwise nothing could fire
    assign target = (act.persist == 8'h00) ? 8'h01 : act.persist;

    // run length: any quiet sample restarts it, saturates at the top
    always_comb
    begin
        cnt_d = cnt_q;
        evt_d = 1'b0;
        if (act.clear)
        begin
            cnt_d = 8'h00;
        end
        else if (act.smp_valid)
        begin
            if (hit)
            begin
                cnt_d = (cnt_q == 8'hFF) ? cnt_q : cnt_q + 8'h01;
                evt_d = ({1'b0, cnt_q} + 9'h001) == {1'b0, target};
            end
            else
            begin
                cnt_d = 8'h00;
            end
        end
    end

    // state flops
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            cnt_q <= 8'h00;
            evt_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            evt_q <= evt_d;
        end
    end

    assign act.act_evt = evt_q;

    chk_quiet_resets_run: assert property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (act.smp_valid && !act.clear && !hit) |=> (cnt_q == 8'h00) && !act.act_evt)
        else $error("quiet sample did not restart the run");

    chk_event_run_length: assert property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        act.act_evt |-> (cnt_q == target) && $past(hit))
        else $error("activity event at wrong run length");
endmodule

// File: rtl/msh_host_regs.sv
// serial register link slave with fifo pop port, keyed restart and
// activity level registers; drives the activity detector
// assumes link pins are asynchronous to sys_clk_i and the link clock is
// well below a quarter of the system clock; fifo word is show-ahead
`timescale 1ns/100ps
`include "msh_regs.svh"

// Functional notes
// - reading pop address removes one fifo word
// - word delivered by two reads or burst
// - continued reading keeps popping further words
// - burst at pop address keeps pointer fixed
// - auto-increment onto pop address skips it
// - key write restarts: clears settings, standby
// - after restart interrupt pins go undriven
// - restart register reads as zero
// - compare magnitude of signed sample
// - upper level register holds bits 12..6
// - lower level register holds bits 5..0
// - level counts raw codes, scales with range
// - event after run of samples above level
module msh_host_regs
    import msh_pkg::*;
#(
    parameter int unsigned RST_LAT_CYC = int'(`MSH_RST_LAT_MS * 1000.0 * `MSH_CLK_MHZ)
)
(
    input wire logic sys_clk_i,        // system clock, 250 MHz
    input wire logic reset_n_i,        // async reset, active low
    input wire logic spi_sclk_i,       // link clock pin
    input wire logic spi_cs_n_i,       // link select pin, active low
    input wire logic spi_mosi_i,       // link data in pin
    output logic spi_miso_o,           // link data out pin
    output logic spi_miso_oe_o,        // link data out enable
    input wire logic [15:0] fifo_word_i, // head fifo word, show-ahead
    output logic fifo_pop_o,           // removes head word
    input wire logic smp_valid_i,      // new sample set
    input wire msh_sample_t smp_x_i,   // x sample
    input wire msh_sample_t smp_y_i,   // y sample
    input wire msh_sample_t smp_z_i,   // z sample
    output logic act_evt_o,            // activity event pulse
    output logic soft_rst_o,           // restart pulse to the device
    output logic standby_o,            // sensor held in standby
    input wire logic measure_req_i,    // leave standby
    output logic int_drive_o,          // interrupt pins driven
    input wire logic int_drive_req_i,  // enable interrupt drivers
    output logic busy_o                // restart latency running
);
    localparam int LAT_W = $clog2(RST_LAT_CYC + 1);

    // refuse a latency shorter than the quiet window that the link promises
    if (RST_LAT_CYC < 8)
    begin : g_chk_lat
        $error("RST_LAT_CYC must be at least eight cycles");
    end

    logic [2:0] sync1_q;      // first stage: sclk, cs_n, mosi
    logic [2:0] sync2_q;      // second stage
    logic sclk_prev_q;        // previous synced clock
    logic sclk_s;             // synced link clock
    logic sel_s;              // synced select, active high
    logic mosi_s;             // synced data in
    logic rise;               // link clock rising edge
    logic fall;               // link clock falling edge
    msh_link_e state_q;       // link phase
    msh_link_e state_d;
    logic [2:0] bit_cnt_q;    // bits of current byte
    logic [6:0] rx_q;         // received bits so far
    msh_byte_t rx_byte;       // full byte at the eighth edge
    logic byte_done;          // eighth rising edge
    msh_byte_t tx_q;          // outgoing byte
    logic [6:0] ptr_q;        // register address pointer
    logic [6:0] ptr_next;     // pointer after one byte
    logic [6:0] ptr_inc;      // plain increment
    logic commit;             // read byte slot taken by host
    logic wr_stb;             // written byte complete
    logic phase_q;            // low half of popped word pending
    msh_byte_t lo_hold_q;     // low half of popped word
    logic [6:0] lvl_up_q;     // motion level bits 12..6
    logic [5:0] lvl_lo_q;     // motion level bits 5..0
    logic [7:0] persist_q;    // motion persist count
    msh_byte_t rd_data;       // selected read byte
    logic soft_rst_q;         // restart pulse
    logic restart_hit;        // key written to restart register
    logic [LAT_W-1:0] lat_q;  // restart latency counter
    logic pop_now;            // pop on this slot
    logic standby_q;          // standby flag
    logic int_drv_q;          // interrupt drive flag

    // two-stage synchronisers, then one more clock stage for edge finding
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            sync1_q <= 3'h2;
            sync2_q <= 3'h2;
            sclk_prev_q <= 1'b0;
        end
        else
        begin
            sync1_q <= {spi_mosi_i, spi_cs_n_i, spi_sclk_i};
            sync2_q <= sync1_q;
            sclk_prev_q <= sync2_q[0];
        end
    end

    assign sclk_s = sync2_q[0];
    assign sel_s = ~sync2_q[1];
    assign mosi_s = sync2_q[2];
    assign rise = sclk_s && !sclk_prev_q;
    assign fall = !sclk_s && sclk_prev_q;
    assign rx_byte = {rx_q, mosi_s};
    assign byte_done = rise && (bit_cnt_q == 3'h7);
    // first rising edge of a read slot: the host is committed to this byte
    assign commit = rise && (bit_cnt_q == 3'h0) && (state_q == LINK_READ);
    assign wr_stb = byte_done && (state_q == LINK_WRITE);

    // pointer stays on the pop port in reads, hops over it otherwise
    assign ptr_inc = ptr_q + 7'h01;
    assign ptr_next = (state_q == LINK_READ && ptr_q == `MSH_ADDR_FIFO_POP) ? ptr_q
        : (ptr_inc == `MSH_ADDR_FIFO_POP) ? `MSH_ADDR_FIFO_NEXT : ptr_inc;

    // only the first half of a word pops; the second half comes from the hold
    assign pop_now = commit && (ptr_q == `MSH_ADDR_FIFO_POP) && !phase_q;
    assign fifo_pop_o = pop_now;

    // read selection; reserved bits and unmapped addresses give zero
    assign rd_data = (ptr_q == `MSH_ADDR_FIFO_POP) ? (phase_q ? lo_hold_q : fifo_word_i[15:8])
        : (ptr_q == `MSH_ADDR_RESTART) ? `MSH_RESTART_READ
        : (ptr_q == `MSH_ADDR_LVL_UPPER) ? {1'b0, lvl_up_q}
        : (ptr_q == `MSH_ADDR_LVL_LOWER) ? {lvl_lo_q, 2'b00}
        : (ptr_q == `MSH_ADDR_PERSIST) ? persist_q
        : 8'h00;

    assign restart_hit = wr_stb && (ptr_q == `MSH_ADDR_RESTART) && (rx_byte == `MSH_RESTART_KEY);

    // link phase: select opens a command byte, its read flag picks the rest
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            LINK_IDLE:
            begin
                if (sel_s)
                begin
                    state_d = LINK_CMD;
                end
            end
            LINK_CMD:
            begin
                if (byte_done)
                begin
                    state_d = rx_byte[`MSH_CMD_READ_BIT] ? LINK_READ : LINK_WRITE;
                end
            end
            LINK_WRITE, LINK_READ:
            begin
                state_d = state_q;
            end
            default:
            begin
                state_d = LINK_IDLE;
            end
        endcase
        // the host must stay away during the latency; anything it sends is dropped
        if (!sel_s || busy_o || soft_rst_q)
        begin
            state_d = LINK_IDLE;
        end
    end

    // shifter, bit count and link phase
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state_q <= LINK_IDLE;
            bit_cnt_q <= 3'h0;
            rx_q <= 7'h00;
        end
        else
        begin
            state_q <= state_d;
            if (state_d == LINK_IDLE)
            begin
                bit_cnt_q <= 3'h0;
            end
            else if (rise)
            begin
                bit_cnt_q <= bit_cnt_q + 3'h1;
                rx_q <= rx_byte[6:0];
            end
        end
    end

    // outgoing byte: loaded at the slot's opening falling edge from a peek,
    // so a burst that stops never loses a word to prefetch
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            tx_q <= 8'h00;
        end
        else if (fall && state_q == LINK_READ)
        begin
            tx_q <= (bit_cnt_q == 3'h0) ? rd_data : {tx_q[6:0], 1'b0};
        end
    end

    assign spi_miso_o = tx_q[7];
    assign spi_miso_oe_o = (state_q == LINK_READ);

    // pointer, pop pairing and the low half of the popped word
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            ptr_q <= 7'h00;
            phase_q <= 1'b0;
            lo_hold_q <= 8'h00;
        end
        else if (soft_rst_q)
        begin
            ptr_q <= 7'h00;
            phase_q <= 1'b0;
            lo_hold_q <= 8'h00;
        end
        else
        begin
            if (state_q == LINK_CMD && byte_done)
            begin
                ptr_q <= rx_byte[6:0];
            end
            else if (commit || wr_stb)
            begin
                ptr_q <= ptr_next;
            end
            if (pop_now)
            begin
                phase_q <= 1'b1;
                lo_hold_q <= fifo_word_i[7:0];
            end
            else if (commit && ptr_q == `MSH_ADDR_FIFO_POP)
            begin
                phase_q <= 1'b0;
            end
        end
    end

    // level and persist registers; writes to the pop port fall through
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            lvl_up_q <= `MSH_RST_LVL_UPPER;
            lvl_lo_q <= `MSH_RST_LVL_LOWER;
            persist_q <= `MSH_RST_PERSIST;
        end
        else if (soft_rst_q)
        begin
            lvl_up_q <= `MSH_RST_LVL_UPPER;
            lvl_lo_q <= `MSH_RST_LVL_LOWER;
            persist_q <= `MSH_RST_PERSIST;
        end
        else if (wr_stb)
        begin
            if (ptr_q == `MSH_ADDR_LVL_UPPER)
            begin
                lvl_up_q <= rx_byte[`MSH_UPPER_MSB:0];
            end
            if (ptr_q == `MSH_ADDR_LVL_LOWER)
            begin
                lvl_lo_q <= rx_byte[7:`MSH_LOWER_LSB];
            end
            if (ptr_q == `MSH_ADDR_PERSIST)
            begin
                persist_q <= rx_byte;
            end
        end
    end

    // restart pulse, latency counter, standby and interrupt drive flags
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            soft_rst_q <= 1'b0;
            lat_q <= '0;
            standby_q <= 1'b1;
            int_drv_q <= 1'b0;
        end
        else
        begin
            soft_rst_q <= restart_hit;
            if (soft_rst_q)
            begin
                lat_q <= LAT_W'(RST_LAT_CYC);
                standby_q <= 1'b1;
                int_drv_q <= 1'b0;
            end
            else
            begin
                if (lat_q != '0)
                begin
                    lat_q <= lat_q - LAT_W'(1);
                end
                if (measure_req_i)
                begin
                    standby_q <= 1'b0;
                end
                if (int_drive_req_i)
                begin
                    int_drv_q <= 1'b1;
                end
            end
        end
    end

    assign soft_rst_o = soft_rst_q;
    assign busy_o = (lat_q != '0);
    assign standby_o = standby_q;
    assign int_drive_o = int_drv_q;

    // activity detector
    msh_act_if act ();
    assign act.level = {lvl_up_q, lvl_lo_q};
    assign act.persist = persist_q;
    assign act.clear = soft_rst_q;
    assign act.smp_valid = smp_valid_i;
    assign act.smp[0] = smp_x_i;
    assign act.smp[1] = smp_y_i;
    assign act.smp[2] = smp_z_i;
    assign act_evt_o = act.act_evt;

    msh_act_det u_det (
        .sys_clk_i (sys_clk_i),
        .reset_n_i (reset_n_i),
        .act (act)
    );

    chk_pop_at_port: assert property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        fifo_pop_o |-> (state_q == LINK_READ) && (tx_q == fifo_word_i[15:8]))
        else $error("fifo popped without its upper byte on the link");
    chk_word_pairing: assert property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        fifo_pop_o |=> phase_q && (lo_hold_q == $past(fifo_word_i[7:0])))
        else $error("popped word low half not held");
    chk_burst_repop: assert property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (commit && ptr_q == `MSH_ADDR_FIFO_POP && phase_q && !soft_rst_q) |=> !phase_q)
        else $error("burst did not rearm the next pop");
    chk_ptr_fixed: assert property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (commit && ptr_q == `MSH_ADDR_FIFO_POP && !soft_rst_q) |=> ptr_q == `MSH_ADDR_FIFO_POP)
        else $error("pointer moved off the pop port");
    chk_skip_no_pop: assert property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (commit && ptr_q == `MSH_ADDR_FIFO_PREV && !soft_rst_q)
        |=> (ptr_q == `MSH_ADDR_FIFO_NEXT) && !fifo_pop_o)
        else $error("auto-increment did not skip the pop port");
    chk_restart_clear: assert property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        restart_hit |=> soft_rst_o ##1 standby_o && (persist_q == 8'h00) && (act.level == 13'h0000))
        else $error("restart did not clear settings");
    chk_int_release: assert property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        soft_rst_o |=> !int_drive_o)
        else $error("interrupt pins still driven after restart");
    chk_restart_reads: assert property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (fall && state_q == LINK_READ && bit_cnt_q == 3'h0 && ptr_q == `MSH_ADDR_RESTART)
        |=> tx_q == 8'h00)
        else $error("restart register read not zero");
    chk_quiet_window: assert property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        soft_rst_o |=> (busy_o && state_q == LINK_IDLE) [*8])
        else $error("link answered during restart latency");
    chk_reserved_zero: assert property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (ptr_q == `MSH_ADDR_LVL_UPPER) |-> !rd_data[7])
        else $error("reserved upper level bit reads nonzero");
    chk_lower_reserved: assert property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (ptr_q == `MSH_ADDR_LVL_LOWER) |-> (rd_data[1:0] == 2'b00))
        else $error("reserved lower level bits read nonzero");
    chk_pop_write_ignored: assert property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (wr_stb && ptr_q == `MSH_ADDR_FIFO_POP)
        |=> !fifo_pop_o && (phase_q == $past(phase_q)) && (act.level == $past(act.level))
        && (persist_q == $past(persist_q)))
        else $error("write to the pop port changed state");
endmodule

// File: verif/msh_host_model.sv
// host controller model: drives the serial register link, mode 0, msb first
// assumes the device samples the pins with its own much faster clock
`timescale 1ns/100ps
module msh_host_model #(
    parameter real HALF_NS = 40.0 // half period of the 80 ns link clock
)
(
    output logic sclk_o, // link clock, still outside frames
    output logic cs_n_o, // select, active low
    output logic mosi_o, // data to the device
    input wire logic miso_i // data from the device
);
    initial
    begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end

    // one frame: command byte, then n data bytes; bytes read come back in rd
    // a word is fetched as its two bytes in one burst or two frames
    task automatic xfer(input logic [7:0] cmd, input int n, input logic [31:0] wd,
                        output logic [31:0] rd);
        logic [39:0] sh;
        sh = {cmd, wd};
        rd = 32'h0;
        cs_n_o <= 1'b0;
        for (int i = 0; i < 8 * (n + 1); i++)
        begin
            mosi_o <= sh[39];
            sh = sh << 1;
            #(HALF_NS) sclk_o <= 1'b1;
            if (i >= 8)
                rd = {rd[30:0], miso_i}; // sampled on the rising edge
            #(HALF_NS) sclk_o <= 1'b0;
        end
        // released data line shows no stale bit
        #(HALF_NS) cs_n_o <= 1'b1;
        mosi_o <= ~mosi_o;
        #(2.0 * HALF_NS);
    endtask
endmodule

// File: verif/tb.sv
// self-checking bench of the host register block: link frames, fifo pops,
// activity events and keyed restart
// assumes the host model above and a show-ahead fifo modelled here
`timescale 1ns/100ps
`include "msh_regs.svh"
module tb;
    import msh_pkg::*;
    localparam int unsigned LAT = 20; // short restart latency for simulation
    logic sys_clk, reset_n, sclk, cs_n, mosi, miso, miso_oe, pop, evt, srst;
    logic stby, intd, busy, smp_valid, meas_req, int_req;
    logic miso_pin; // data out line as the host sees it
    msh_sample_t sx, sy, sz; // axis samples
    logic [15:0] pops, evts, srsts, busy_cyc; // event counters
    logic [15:0] fifo_word; // head word depends on pops taken
    logic [31:0] rd;
    int n_errors, checks_done;

    assign fifo_word = {8'hA0 + pops[7:0], 8'h50 + pops[7:0]};
    // a released data out line shows the inverse, so reads outside the data phase fail
    assign miso_pin = miso_oe ? miso : ~miso;

    msh_host_regs #(.RST_LAT_CYC(LAT)) i_msh_host_regs (
        .sys_clk_i(sys_clk), .reset_n_i(reset_n), .spi_sclk_i(sclk),
        .spi_cs_n_i(cs_n), .spi_mosi_i(mosi), .spi_miso_o(miso),
        .spi_miso_oe_o(miso_oe), .fifo_word_i(fifo_word), .fifo_pop_o(pop),
        .smp_valid_i(smp_valid), .smp_x_i(sx), .smp_y_i(sy), .smp_z_i(sz),
        .act_evt_o(evt), .soft_rst_o(srst), .standby_o(stby),
        .measure_req_i(meas_req), .int_drive_o(intd),
        .int_drive_req_i(int_req), .busy_o(busy));

    msh_host_model i_msh_host_model (
        .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso_pin));

    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // count pulses and busy cycles as the design shows them
    always @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            {pops, evts, srsts, busy_cyc} <= 64'h0;
        end
        else
        begin
            pops <= pops + {15'h0, pop};
            evts <= evts + {15'h0, evt};
            srsts <= srsts + {15'h0, srst};
            busy_cyc <= busy_cyc + {15'h0, busy};
        end
    end

    task automatic chk_b(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_n(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rd_reg(input logic [6:0] a, input int n);
        i_msh_host_model.xfer({1'b1, a}, n, 32'h0, rd);
    endtask

    task automatic wr_reg(input logic [6:0] a, input int n, input logic [31:0] d);
        i_msh_host_model.xfer({1'b0, a}, n, d, rd);
    endtask

    // one sample set, then a few quiet cycles for the event to land
    task automatic smp(input msh_sample_t x, input msh_sample_t y, input msh_sample_t z);
        @(posedge sys_clk);
        smp_valid <= 1'b1;
        sx <= x;
        sy <= y;
        sz <= z;
        @(posedge sys_clk);
        smp_valid <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask

    // no access while the restart latency runs; bounded wait
    task automatic wait_idle;
        for (int k = 0; k < 200 && busy !== 1'b0; k++)
            @(negedge sys_clk);
        if (busy !== 1'b0)
        begin
            n_errors++;
            tally_and_finish();
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        reset_n = 1'b0;
        {smp_valid, meas_req, int_req} = 3'h0;
        {sx, sy, sz} = '0;
        n_errors = 0;
        checks_done = 0;
        repeat (5) @(posedge sys_clk);
        reset_n <= 1'b1;
        // flags are looked at away from the edge that could move them
        repeat (5) @(negedge sys_clk);
        chk_b({5'h0, stby, intd, busy}, 8'h04);
        rd_reg(`MSH_ADDR_LVL_UPPER, 2);
        chk_n(rd[15:0], 16'h0000);
        rd_reg(`MSH_ADDR_RESTART, 1);
        chk_b(rd[7:0], 8'h00);
        // all ones into both level registers: reserved bits stay zero
        wr_reg(`MSH_ADDR_LVL_UPPER, 2, 32'hFFFF_0000);
        rd_reg(`MSH_ADDR_LVL_UPPER, 2);
        chk_n(rd[15:0], 16'h7FFC);
        // burst at the pop port: hi, lo, hi, lo of two words
        rd_reg(`MSH_ADDR_FIFO_POP, 4);
        chk_n(rd[31:16], 16'hA050);
        chk_n(rd[15:0], 16'hA151);
        chk_n(pops, 16'h0002);
        rd_reg(`MSH_ADDR_FIFO_POP, 1);
        chk_b(rd[7:0], 8'hA2);
        rd_reg(`MSH_ADDR_FIFO_POP, 1);
        chk_b(rd[7:0], 8'h52);
        // burst from the address below skips the pop port
        rd_reg(`MSH_ADDR_FIFO_PREV, 2);
        chk_n(rd[15:0], 16'h0000);
        chk_n(pops, 16'h0003);
        wr_reg(`MSH_ADDR_FIFO_POP, 1, 32'hFF00_0000);
        chk_n(pops, 16'h0003);
        // level 10 codes, two samples in a row
        wr_reg(`MSH_ADDR_LVL_UPPER, 3, 32'h0028_0200);
        rd_reg(`MSH_ADDR_PERSIST, 1);
        chk_b(rd[7:0], 8'h02);
        @(posedge sys_clk);
        {meas_req, int_req} <= 2'h3;
        @(posedge sys_clk);
        {meas_req, int_req} <= 2'h0;
        // every axis takes its turn; a code equal to the level is quiet
        smp(-14'sh00B, 14'sh000, 14'sh000);
        smp(14'sh00A, -14'sh00A, 14'sh00A);
        smp(14'sh000, -14'sh00B, 14'sh000);
        chk_n(evts, 16'h0000);
        smp(14'sh000, 14'sh000, 14'sh00B);
        chk_n(evts, 16'h0001);
        // a run that goes on fires only once
        smp(14'sh00C, 14'sh000, 14'sh000);
        chk_n(evts, 16'h0001);
        chk_b({6'h0, stby, intd}, 8'h01);
        // a wrong key does nothing, the right one restarts
        wr_reg(`MSH_ADDR_RESTART, 1, 32'h5300_0000);
        chk_n(srsts, 16'h0000);
        wr_reg(`MSH_ADDR_RESTART, 1, 32'h5200_0000);
        wait_idle();
        chk_n(srsts, 16'h0001);
        chk_n(busy_cyc, 16'(LAT));
        chk_b({6'h0, stby, intd}, 8'h02);
        rd_reg(`MSH_ADDR_LVL_UPPER, 3);
        chk_n(rd[15:0], 16'h0000);
        chk_b(rd[23:16], 8'h00);
        tally_and_finish();
    end
endmodule
